// ===== rtl/pbm_irq_enable.sv
`timescale 1ns/1ps
module pbm_irq_enable
   import pbm_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic swRst,
   input wire logic [ADDR_W-1:0] cpuAddr,
   input wire logic cpuWrite,
   input wire logic cpuRead,
   input wire logic [DATA_W-1:0] cpuWdata,
   output logic [DATA_W-1:0] cpuRdata,
   input wire logic ctrlPipeReadyStatus,
   input wire logic [LAST_PIPE_BIT:FIRST_BULK_BIT] pipeReadyStatusFlag,
   input wire logic ctrlPipeNotReadyStatus,
   input wire logic [LAST_PIPE_BIT:FIRST_BULK_BIT] pipeNotReadyStatusFlag,
   input wire logic globalReadyIrqEnable,
   input wire logic globalNotReadyIrqEnable,
   output logic bufferReadySummaryFlag,
   output logic bufferNotReadySummaryFlag,
   output logic irqOut
);

   pbm_pipes_t pipeReadyIrqEnable;
   pbm_pipes_t pipeNotReadyIrqEnable;
   pbm_pipes_t readyStatus;
   pbm_pipes_t notReadyStatus;
   pbm_pipes_t readyGated;
   pbm_pipes_t notReadyGated;
   logic clearAll;
   logic hitReady;
   logic hitNotReady;

   // Address compare shared by write and read paths
   function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] offset);
      addrHit = (addr == offset);
   endfunction

   // Decode of the two register slots
   assign hitReady = addrHit(cpuAddr, READY_EN_OFFSET);
   assign hitNotReady = addrHit(cpuAddr, NOT_READY_EN_OFFSET);
   assign clearAll = sys_rst | swRst;

   // Gather control pipe at bit 0 and pipe n at bit n
   assign readyStatus = {pipeReadyStatusFlag, ctrlPipeReadyStatus};
   assign notReadyStatus = {pipeNotReadyStatusFlag, ctrlPipeNotReadyStatus};

   // Ready enable register, reserved write bits dropped
   always_ff @(posedge clock) begin
      if (clearAll) begin
         pipeReadyIrqEnable <= ENABLE_RESET;
      end else if (cpuWrite && hitReady) begin
         pipeReadyIrqEnable <= cpuWdata[PIPE_COUNT-1:0];
      end
   end

   // Not-ready enable register, reserved write bits dropped
   always_ff @(posedge clock) begin
      if (clearAll) begin
         pipeNotReadyIrqEnable <= ENABLE_RESET;
      end else if (cpuWrite && hitNotReady) begin
         pipeNotReadyIrqEnable <= cpuWdata[PIPE_COUNT-1:0];
      end
   end

   // Read data, one cycle after the strobe; other addresses read zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cpuRdata <= READ_IDLE;
      end else if (cpuRead && hitReady) begin
         cpuRdata <= {RESERVED_READ, pipeReadyIrqEnable};
      end else if (cpuRead && hitNotReady) begin
         cpuRdata <= {RESERVED_READ, pipeNotReadyIrqEnable};
      end else if (cpuRead) begin
         cpuRdata <= READ_IDLE;
      end
   end

   // Per-pipe gating of each status flag by its enable bit
   genvar gi;
   generate
      for (gi = 0; gi < PIPE_COUNT; gi = gi + 1) begin : g_gate
         // Bit 0 is the control pipe, the rest are pipes 1 to 6
         assign readyGated[gi] = readyStatus[gi] &
                                 pipeReadyIrqEnable[gi];
         assign notReadyGated[gi] = notReadyStatus[gi] &
                                    pipeNotReadyIrqEnable[gi];
      end
   endgenerate

   // Summary flags follow any enabled pipe flag
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bufferReadySummaryFlag <= 1'b0;
         bufferNotReadySummaryFlag <= 1'b0;
      end else begin
         bufferReadySummaryFlag <= |readyGated;
         bufferNotReadySummaryFlag <= |notReadyGated;
      end
   end

   // Interrupt output, each summary gated by its global enable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= (bufferReadySummaryFlag & globalReadyIrqEnable) |
                   (bufferNotReadySummaryFlag &
                    globalNotReadyIrqEnable);
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // Write to a slot followed by a read of the same slot
   sequence s_write_ready;
      cpuWrite && hitReady && !swRst && !cpuRead;
   endsequence
   sequence s_read_ready;
      cpuRead && hitReady && !cpuWrite && !swRst;
   endsequence
   sequence s_write_not_ready;
      cpuWrite && hitNotReady && !swRst && !cpuRead;
   endsequence
   sequence s_read_not_ready;
      cpuRead && hitNotReady && !cpuWrite && !swRst;
   endsequence

   // Summary becomes set once status meets enable
   sequence s_ready_cause;
      (|(readyStatus & pipeReadyIrqEnable));
   endsequence

   chk_ready_readback: assert property (
      (s_write_ready ##1 s_read_ready) |=>
      cpuRdata == {RESERVED_READ, $past(cpuWdata[PIPE_COUNT-1:0], 2)})
      else $error("ready enable readback mismatch");

   chk_not_ready_readback: assert property (
      (s_write_not_ready ##1 s_read_not_ready) |=>
      cpuRdata == {RESERVED_READ, $past(cpuWdata[PIPE_COUNT-1:0], 2)})
      else $error("not-ready enable readback mismatch");

   chk_reserved_zero: assert property (
      cpuRead |=> cpuRdata[DATA_W-1:PIPE_COUNT] == RESERVED_READ)
      else $error("reserved bits read nonzero");

   chk_soft_reset_clear: assert property (
      swRst |=> (pipeReadyIrqEnable == ENABLE_RESET) &&
                (pipeNotReadyIrqEnable == ENABLE_RESET))
      else $error("software reset left an enable set");

   chk_ready_summary: assert property (
      s_ready_cause |=> bufferReadySummaryFlag)
      else $error("enabled ready flag did not set summary");

   chk_ctrl_ready_mask: assert property (
      (!pipeReadyIrqEnable[CTRL_PIPE_BIT] &&
       !(|readyGated[LAST_PIPE_BIT:FIRST_BULK_BIT])) |=>
      !bufferReadySummaryFlag)
      else $error("masked control pipe set ready summary");

   chk_not_ready_summary: assert property (
      (|notReadyGated[LAST_PIPE_BIT:FIRST_BULK_BIT]) |=>
      bufferNotReadySummaryFlag)
      else $error("enabled not-ready flag did not set summary");

   chk_ctrl_not_ready: assert property (
      (notReadyStatus == pbm_pipes_t'(1) &&
       !pipeNotReadyIrqEnable[CTRL_PIPE_BIT]) |=>
      !bufferNotReadySummaryFlag)
      else $error("masked control pipe set not-ready summary");

   chk_irq_ready_path: assert property (
      (s_ready_cause ##1 globalReadyIrqEnable) |=> irqOut)
      else $error("ready summary did not raise interrupt");

   chk_irq_not_ready: assert property (
      (bufferNotReadySummaryFlag && globalNotReadyIrqEnable) |=> irqOut)
      else $error("not-ready summary did not raise interrupt");

   chk_irq_quiet: assert property (
      (!(bufferReadySummaryFlag && globalReadyIrqEnable) &&
       !(bufferNotReadySummaryFlag && globalNotReadyIrqEnable)) |=>
      !irqOut)
      else $error("interrupt raised without enabled summary");

   chk_offset_decode: assert property (
      (cpuWrite && !hitReady && !swRst) |=>
      $stable(pipeReadyIrqEnable))
      else $error("ready enable changed on foreign address");

   // Reads of unused addresses return zero
   chk_unmapped_read: assert property (
      (cpuRead && !hitReady && !hitNotReady) |=> cpuRdata == READ_IDLE)
      else $error("unmapped read returned nonzero");

   // A cleared enable keeps its pipe out of the summary
   chk_ready_blocked: assert property (
      !(|readyGated) |=> !bufferReadySummaryFlag)
      else $error("blocked ready pipes set summary");

   chk_not_ready_blocked: assert property (
      !(|notReadyGated) |=> !bufferNotReadySummaryFlag)
      else $error("blocked not-ready pipes set summary");

   chk_not_ready_decode: assert property (
      (cpuWrite && !hitNotReady && !swRst) |=>
      $stable(pipeNotReadyIrqEnable))
      else $error("not-ready enable changed on foreign address");

endmodule

// ===== shared/pbm_pkg.sv
package pbm_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   // Byte offsets of the two enable registers
   localparam logic [7:0] READY_EN_OFFSET = 8'h44;
   localparam logic [7:0] NOT_READY_EN_OFFSET = 8'h48;
   // Control pipe plus pipes 1 to 6
   localparam int PIPE_COUNT = 7;
   localparam int CTRL_PIPE_BIT = 0;
   localparam int FIRST_BULK_BIT = 1;
   localparam int LAST_PIPE_BIT = 6;
   // Reset value of both enable registers
   localparam logic [6:0] ENABLE_RESET = 7'h00;
   // Reserved upper bits read back as zero
   localparam logic [8:0] RESERVED_READ = 9'h000;
   localparam logic [15:0] READ_IDLE = 16'h0000;
   typedef logic [PIPE_COUNT-1:0] pbm_pipes_t;
endpackage

// ===== testbench/pbm_host_model.sv
`timescale 1ns/1ps
// Host CPU on the register bus, one strobe per access
module pbm_host_model
   import pbm_pkg::*;
(
   input wire logic clock,
   output logic [ADDR_W-1:0] cpuAddr,
   output logic cpuWrite,
   output logic cpuRead,
   output logic [DATA_W-1:0] cpuWdata,
   input wire logic [DATA_W-1:0] cpuRdata
);
   // Idle bus at time zero
   initial begin
      cpuAddr = 8'h00;
      cpuWrite = 1'b0;
      cpuRead = 1'b0;
      cpuWdata = 16'h0000;
   end
   // Write; released lines are inverted so stale values never match
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      cpuAddr <= a;
      cpuWdata <= d;
      cpuWrite <= 1'b1;
      @(posedge clock);
      cpuWrite <= 1'b0;
      cpuAddr <= ~a;
      cpuWdata <= ~d;
   endtask
   // Write, then read the same slot on the very next edge
   task automatic wrRd(input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge clock);
      cpuAddr <= a;
      cpuWdata <= d;
      cpuWrite <= 1'b1;
      @(posedge clock);
      cpuWrite <= 1'b0;
      cpuRead <= 1'b1;
      @(posedge clock);
      cpuRead <= 1'b0;
      cpuAddr <= ~a;
      cpuWdata <= ~d;
      @(negedge clock);
      q = cpuRdata;
   endtask
   // Read; data is taken half a cycle after the edge that samples the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      cpuAddr <= a;
      cpuRead <= 1'b1;
      @(posedge clock);
      cpuRead <= 1'b0;
      cpuAddr <= ~a;
      @(negedge clock);
      d = cpuRdata;
   endtask
endmodule

// ===== testbench/pbm_irq_enable_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the per-pipe enable masks
module pbm_irq_enable_tb import pbm_pkg::*;;
   logic clock = 1'b0, sys_rst = 1'b1, swRst = 1'b0;
   logic [7:0] cpuAddr;
   logic cpuWrite, cpuRead, sumR, sumN, irq, exR, exN;
   logic [15:0] cpuWdata, cpuRdata, rv;
   logic ctrlR = 1'b0, ctrlN = 1'b0, gR = 1'b1, gN = 1'b1;
   logic [6:1] rdy = '0, nrdy = '0;
   logic [6:0] en, st;
   int nErrors = 0, numChecks = 0;
   // Rows: ready enable, status, ready summary, not-ready summary
   logic [15:0] rows [7] = '{{7'h01, 7'h01, 2'b10}, {7'h7E, 7'h01, 2'b01},
      {7'h40, 7'h40, 2'b10}, {7'h02, 7'h02, 2'b10}, {7'h3F, 7'h40, 2'b01},
      {7'h00, 7'h7F, 2'b01}, {7'h08, 7'h0F, 2'b11}};
   pbm_host_model host (.clock(clock), .cpuAddr(cpuAddr),
      .cpuWrite(cpuWrite), .cpuRead(cpuRead), .cpuWdata(cpuWdata),
      .cpuRdata(cpuRdata));
   pbm_irq_enable pbm_irq_enable_i (.clock(clock), .sys_rst(sys_rst),
      .swRst(swRst), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
      .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
      .ctrlPipeReadyStatus(ctrlR), .pipeReadyStatusFlag(rdy),
      .ctrlPipeNotReadyStatus(ctrlN), .pipeNotReadyStatusFlag(nrdy),
      .globalReadyIrqEnable(gR), .globalNotReadyIrqEnable(gN),
      .bufferReadySummaryFlag(sumR), .bufferNotReadySummaryFlag(sumN),
      .irqOut(irq));
   // Clock at 40 ns
   initial begin
      forever #20 clock = ~clock;
   end
   // Compare and count
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      numChecks++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", nm, e, s);
         nErrors++;
      end
   endtask
   // Verdict
   task automatic wrapUp();
      if (nErrors == 0 && numChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (3000) @(posedge clock);
      nErrors++;
      wrapUp();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      host.rd(READY_EN_OFFSET, rv);
      chk("rdyRst", 16'h0000, rv);
      host.rd(NOT_READY_EN_OFFSET, rv);
      chk("nrdyRst", 16'h0000, rv);
      foreach (rows[k]) begin
         {en, st, exR, exN} = rows[k];
         host.wr(READY_EN_OFFSET, {9'h000, en});
         host.wr(NOT_READY_EN_OFFSET, {9'h000, ~en});
         @(posedge clock);
         {rdy, ctrlR} <= st;
         {nrdy, ctrlN} <= st;
         repeat (3) @(posedge clock);
         #1;
         chk("sumR", 16'(exR), 16'(sumR));
         chk("sumN", 16'(exN), 16'(sumN));
         chk("irq", 16'(exR | exN), 16'(irq));
      end
      host.wrRd(READY_EN_OFFSET, 16'h007F, rv);
      chk("rdyRb", 16'h007F, rv);
      host.wr(NOT_READY_EN_OFFSET, 16'h007F);
      host.rd(NOT_READY_EN_OFFSET, rv);
      chk("nrdyRb", 16'h007F, rv);
      host.wrRd(NOT_READY_EN_OFFSET, 16'h002A, rv);
      chk("nrdyB2b", 16'h002A, rv);
      host.rd(8'h46, rv);
      chk("unmapped", 16'h0000, rv);
      @(posedge clock);
      gR <= 1'b0;
      gN <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("irqMask", 16'h0000, 16'(irq));
      @(posedge clock);
      gN <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("irqN", 16'h0001, 16'(irq));
      @(posedge clock);
      swRst <= 1'b1;
      @(posedge clock);
      swRst <= 1'b0;
      host.rd(READY_EN_OFFSET, rv);
      chk("swRst", 16'h0000, rv);
      host.rd(NOT_READY_EN_OFFSET, rv);
      chk("swRstN", 16'h0000, rv);
      chk("sumSw", 16'h0000, 16'(sumN));
      // Hardware reset in mid-run after both enables are set
      host.wr(READY_EN_OFFSET, 16'h007F);
      host.wr(NOT_READY_EN_OFFSET, 16'h007F);
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      host.rd(READY_EN_OFFSET, rv);
      chk("rdyHw", 16'h0000, rv);
      host.rd(NOT_READY_EN_OFFSET, rv);
      chk("nrdyHw", 16'h0000, rv);
      chk("sumHw", 16'h0000, 16'({sumR, sumN, irq}));
      wrapUp();
   end
endmodule
